// [hdl/rss_ready_select.sv]
// Ready-source selector with word recognizers and an APB register file.
// Assumes the processor raises cyc_start for one cycle only while no cycle is open,
// and that all inputs are synchronous to pclk.
//
// Notes on behaviour
// - Combine on, emulator mapping: processor ready is target ready AND emulator ready.
// - Combine off: ready comes from the mapped resource only.
// - Combine bit is write data bit 0, one means on; reset off.
// - Five ready origins, one chosen per cycle from the address map.
// - Combine on, emulator memory: wait for both target and memory ready.
// - Combine off, emulator memory: target ready is ignored.
// - Combine off, non-target mapping: cycle ends on the mapped resource's ready.
// - Each recognizer below the break count compares its pattern to the bus; a match halts emulation.
// - Flag an error when a break needs more recognizers than exist.
// - Target-mapped cycles use only the target ready, whatever combine says.
`timescale 1ns/100ps

module rss_ready_select (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Processor bus cycle
	input  wire logic                  cyc_start,
	input  wire rss_pkg::rss_cycle_t   cyc_info,
	input  wire rss_pkg::rss_ready_in_t ready_in,
	output logic                       proc_ready,
	// Emulation control
	output logic                       halt_emulation,
	output logic                       irq
);
	import rss_pkg::*;

	// ------------------------------------------------------------
	// Register bus decode
	// ------------------------------------------------------------
	logic                        setup_ph;
	logic                        wr_en;
	logic                        hit_ctrl;
	logic                        hit_mem_map;
	logic                        hit_io_map;
	logic                        hit_brk;
	logic                        hit_status;
	logic                        hit_int_clr;
	logic                        hit_int_en;
	logic                        hit_wr_lo;
	logic                        hit_wr_hi;
	logic                        addr_ok;
	logic [1:0]                  wr_idx;

	assign setup_ph    = psel & ~penable;
	assign wr_en       = psel & penable & pwrite & addr_ok;
	assign hit_ctrl    = (paddr == RSS_OFF_CTRL);
	assign hit_mem_map = (paddr == RSS_OFF_MEM_MAP);
	assign hit_io_map  = (paddr == RSS_OFF_IO_MAP);
	assign hit_brk     = (paddr == RSS_OFF_BRK_REQ);
	assign hit_status  = (paddr == RSS_OFF_STATUS);
	assign hit_int_clr = (paddr == RSS_OFF_INT_CLR);
	assign hit_int_en  = (paddr == RSS_OFF_INT_EN);
	assign hit_wr_lo   = (paddr[7:4] == RSS_OFF_WR_LO[7:4]) & (paddr[1:0] == 2'h0);
	assign hit_wr_hi   = (paddr[7:4] == RSS_OFF_WR_HI[7:4]) & (paddr[1:0] == 2'h0);
	assign wr_idx      = paddr[3:2];
	assign addr_ok     = hit_ctrl | hit_mem_map | hit_io_map | hit_brk | hit_status
	                   | hit_int_clr | hit_int_en | hit_wr_lo | hit_wr_hi;

	// Zero wait states; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic                        combine_reg;
	logic [31:0]                 mem_map_reg;
	logic [15:0]                 io_map_reg;
	logic [2:0]                  brk_cnt_reg;
	logic [RSS_NUM_WR-1:0]       brk_out_reg;
	logic [RSS_NUM_EV-1:0]       int_en_reg;
	logic [RSS_ADDR_W-1:0]       wr_lo_reg [RSS_NUM_WR];
	logic [RSS_ADDR_W-1:0]       wr_hi_reg [RSS_NUM_WR];
	logic                        brk_wr;
	logic                        brk_too_many;
	logic                        resume_wr;

	assign brk_wr       = wr_en & hit_brk;
	// Any count beyond the recognizer pool is refused and flagged
	assign brk_too_many = brk_wr & (pwdata[2:0] > 3'(RSS_NUM_WR));
	assign resume_wr    = wr_en & hit_ctrl & pwdata[RSS_CTRL_RESUME_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			combine_reg <= RSS_COMBINE_RST;
			mem_map_reg <= RSS_MEM_MAP_RST;
			io_map_reg  <= RSS_IO_MAP_RST;
			int_en_reg  <= '0;
		end else if (wr_en) begin
			if (hit_ctrl)
				combine_reg <= pwdata[RSS_CTRL_COMBINE_BIT];
			if (hit_mem_map)
				mem_map_reg <= pwdata;
			if (hit_io_map)
				io_map_reg <= pwdata[15:0];
			if (hit_int_en)
				int_en_reg <= pwdata[RSS_NUM_EV-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brk_cnt_reg <= RSS_BRK_CNT_RST;
			brk_out_reg <= '0;
		end else if (brk_wr && !brk_too_many) begin
			brk_cnt_reg <= pwdata[2:0];
			brk_out_reg <= pwdata[RSS_BRK_OUT_LSB +: RSS_NUM_WR];
		end
	end

	// ------------------------------------------------------------
	// Address map decode and source selection
	// ------------------------------------------------------------
	logic [1:0]                  mem_code;
	logic                        io_sysbus;
	rss_src_t                    src_dec;
	rss_src_t                    src_reg;
	logic                        comb_lat_reg;
	rss_state_t                  state_reg;
	rss_state_t                  state_next;

	// One 64K block per two-bit code, one 4K-port block per I/O bit
	assign mem_code  = mem_map_reg[{cyc_info.addr[19:16], 1'b0} +: 2];
	assign io_sysbus = io_map_reg[cyc_info.addr[15:12]];

	always_comb begin
		src_dec = RSS_SRC_TGT_MEM;
		if (cyc_info.io)
			src_dec = io_sysbus ? RSS_SRC_SB_IO : RSS_SRC_TGT_IO;
		else begin
			case (mem_code)
				RSS_MAP_HS:     src_dec = RSS_SRC_HS_MEM;
				RSS_MAP_OHS:    src_dec = RSS_SRC_OHS_MEM;
				RSS_MAP_SYSBUS: src_dec = RSS_SRC_SB_MEM;
				default:        src_dec = RSS_SRC_TGT_MEM;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Ready merging
	// ------------------------------------------------------------
	logic                        mapped_ready;
	logic                        sel_ready;
	logic                        tgt_src;

	assign tgt_src = (src_reg == RSS_SRC_TGT_MEM) || (src_reg == RSS_SRC_TGT_IO);

	always_comb begin
		case (src_reg)
			RSS_SRC_HS_MEM:  mapped_ready = ready_in.high_speed_mem_ready;
			RSS_SRC_OHS_MEM: mapped_ready = ready_in.optional_high_speed_mem_ready;
			RSS_SRC_SB_MEM:  mapped_ready = ready_in.system_bus_mem_ready;
			RSS_SRC_SB_IO:   mapped_ready = ready_in.system_bus_io_ready;
			default:         mapped_ready = ready_in.target_ready;
		endcase
	end

	// Target mappings never see the combine setting; with combine off the target
	// ready is dropped, so a slow target can clash with the probe on the data bus.
	assign sel_ready = tgt_src     ? ready_in.target_ready :
	                   comb_lat_reg ? (ready_in.target_ready & mapped_ready) :
	                                  mapped_ready;

	assign proc_ready = (state_reg == RSS_BUSY) & sel_ready;

	// ------------------------------------------------------------
	// Cycle tracking
	// ------------------------------------------------------------
	always_comb begin
		case (state_reg)
			RSS_IDLE: state_next = cyc_start ? RSS_BUSY : RSS_IDLE;
			RSS_BUSY: state_next = sel_ready ? RSS_IDLE : RSS_BUSY;
			default:  state_next = RSS_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg    <= RSS_IDLE;
			src_reg      <= RSS_SRC_TGT_MEM;
			comb_lat_reg <= RSS_COMBINE_RST;
		end else begin
			state_reg <= state_next;
			// Latched once so a map or combine write mid-cycle cannot glitch ready
			if (state_reg == RSS_IDLE && cyc_start) begin
				src_reg      <= src_dec;
				comb_lat_reg <= combine_reg;
			end
		end
	end

	// ------------------------------------------------------------
	// Word recognizers
	// ------------------------------------------------------------
	logic [RSS_NUM_WR-1:0]       wr_match;
	logic                        any_match;

	for (genvar i = 0; i < RSS_NUM_WR; i++) begin : g_wr
		logic in_range;
		assign in_range    = (cyc_info.addr >= wr_lo_reg[i]) && (cyc_info.addr <= wr_hi_reg[i]);
		assign wr_match[i] = (3'(i) < brk_cnt_reg) & (in_range ^ brk_out_reg[i]);

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				wr_lo_reg[i] <= RSS_WR_ADDR_RST;
				wr_hi_reg[i] <= RSS_WR_ADDR_RST;
			end else if (wr_en && wr_idx == 2'(i)) begin
				if (hit_wr_lo)
					wr_lo_reg[i] <= pwdata[RSS_ADDR_W-1:0];
				if (hit_wr_hi)
					wr_hi_reg[i] <= pwdata[RSS_ADDR_W-1:0];
			end
		end
	end

	// Patterns are compared only when a cycle opens, when the address is valid
	assign any_match = (state_reg == RSS_IDLE) & cyc_start & (|wr_match);

	logic                        halt_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			halt_reg <= 1'b0;
		else if (any_match)
			halt_reg <= 1'b1;
		else if (resume_wr)
			halt_reg <= 1'b0;
	end

	assign halt_emulation = halt_reg;

	// ------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------
	logic [RSS_NUM_EV-1:0]       ev_set;
	logic [RSS_NUM_EV-1:0]       ev_clr;
	logic [RSS_NUM_EV-1:0]       status_reg;

	assign ev_set[RSS_ST_HALT_EV_BIT] = any_match;
	assign ev_set[RSS_ST_OVFL_EV_BIT] = brk_too_many;
	assign ev_clr = (wr_en & hit_int_clr) ? pwdata[RSS_NUM_EV-1:0] : '0;

	// A new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status_reg <= '0;
		else
			status_reg <= ev_set | (status_reg & ~ev_clr);
	end

	assign irq = |(status_reg & int_en_reg);

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [31:0]                 rd_mux;
	logic [31:0]                 rd_status;
	logic [31:0]                 prdata_reg;

	always_comb begin
		rd_status = '0;
		rd_status[RSS_NUM_EV-1:0]                 = status_reg;
		rd_status[RSS_ST_HALTED_BIT]              = halt_reg;
		rd_status[RSS_ST_BUSY_BIT]                = (state_reg == RSS_BUSY);
		rd_status[RSS_ST_SRC_LSB +: 3]            = src_reg;
	end

	always_comb begin
		rd_mux = '0;
		if (hit_ctrl)
			rd_mux[RSS_CTRL_COMBINE_BIT] = combine_reg;
		else if (hit_mem_map)
			rd_mux = mem_map_reg;
		else if (hit_io_map)
			rd_mux[15:0] = io_map_reg;
		else if (hit_brk) begin
			rd_mux[2:0]                            = brk_cnt_reg;
			rd_mux[RSS_BRK_OUT_LSB +: RSS_NUM_WR]  = brk_out_reg;
		end else if (hit_status)
			rd_mux = rd_status;
		else if (hit_int_en)
			rd_mux[RSS_NUM_EV-1:0] = int_en_reg;
		else if (hit_wr_lo)
			rd_mux[RSS_ADDR_W-1:0] = wr_lo_reg[wr_idx];
		else if (hit_wr_hi)
			rd_mux[RSS_ADDR_W-1:0] = wr_hi_reg[wr_idx];
	end

	// Captured in the setup phase so the access phase returns a flopped word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_reg <= '0;
		else if (setup_ph && !pwrite)
			prdata_reg <= rd_mux;
	end

	assign prdata = prdata_reg;

endmodule

// [inc/rss_pkg.sv]
// Package for the ready-source selector of the emulator probe.
// Assumes a 20-bit processor address, an APB slave with 8-bit byte addresses.
package rss_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] RSS_OFF_CTRL    = 8'h00;
	localparam logic [7:0] RSS_OFF_MEM_MAP = 8'h04;
	localparam logic [7:0] RSS_OFF_IO_MAP  = 8'h08;
	localparam logic [7:0] RSS_OFF_BRK_REQ = 8'h0c;
	localparam logic [7:0] RSS_OFF_STATUS  = 8'h10;
	localparam logic [7:0] RSS_OFF_INT_CLR = 8'h14;
	localparam logic [7:0] RSS_OFF_INT_EN  = 8'h18;
	localparam logic [7:0] RSS_OFF_WR_LO   = 8'h20;
	localparam logic [7:0] RSS_OFF_WR_HI   = 8'h30;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int RSS_CTRL_COMBINE_BIT = 0;
	localparam int RSS_CTRL_RESUME_BIT  = 1;
	localparam int RSS_ST_HALT_EV_BIT   = 0;
	localparam int RSS_ST_OVFL_EV_BIT   = 1;
	localparam int RSS_ST_HALTED_BIT    = 8;
	localparam int RSS_ST_BUSY_BIT      = 9;
	localparam int RSS_ST_SRC_LSB       = 12;
	localparam int RSS_BRK_OUT_LSB      = 4;

	// ------------------------------------------------------------
	// Sizes and reset values
	// ------------------------------------------------------------
	localparam int          RSS_NUM_WR        = 4;
	localparam int          RSS_NUM_EV        = 2;
	localparam int          RSS_ADDR_W        = 20;
	localparam logic        RSS_COMBINE_RST   = 1'b0;
	localparam logic [31:0] RSS_MEM_MAP_RST   = 32'h0000_0000;
	localparam logic [15:0] RSS_IO_MAP_RST    = 16'h0000;
	localparam logic [2:0]  RSS_BRK_CNT_RST   = 3'h0;
	localparam logic [19:0] RSS_WR_ADDR_RST   = 20'h0_0000;

	// Mapping codes held two bits per 64K block of memory
	localparam logic [1:0] RSS_MAP_TARGET = 2'h0;
	localparam logic [1:0] RSS_MAP_HS     = 2'h1;
	localparam logic [1:0] RSS_MAP_OHS    = 2'h2;
	localparam logic [1:0] RSS_MAP_SYSBUS = 2'h3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		RSS_SRC_TGT_MEM = 3'b000,
		RSS_SRC_HS_MEM  = 3'b001,
		RSS_SRC_OHS_MEM = 3'b010,
		RSS_SRC_SB_MEM  = 3'b011,
		RSS_SRC_TGT_IO  = 3'b100,
		RSS_SRC_SB_IO   = 3'b101
	} rss_src_t;

	typedef enum logic [0:0] {
		RSS_IDLE = 1'b0,
		RSS_BUSY = 1'b1
	} rss_state_t;

	typedef struct packed {
		logic                  io;
		logic [RSS_ADDR_W-1:0] addr;
	} rss_cycle_t;

	typedef struct packed {
		logic target_ready;
		logic high_speed_mem_ready;
		logic optional_high_speed_mem_ready;
		logic system_bus_mem_ready;
		logic system_bus_io_ready;
	} rss_ready_in_t;

endpackage

// [verification/rss_ready_select_asserts.sv]
// Checker for the ready-source selector, bound to its top-level ports.
// Assumes APB writes land at the access edge and cycles open on an idle cyc_start.
`timescale 1ns/100ps

module rss_ready_select_asserts (
	// Clock and reset
	input wire logic                  pclk,
	input wire logic                  presetn,
	// APB
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [7:0]            paddr,
	input wire logic [31:0]           pwdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	// Processor bus cycle
	input wire logic                  cyc_start,
	input wire rss_pkg::rss_cycle_t   cyc_info,
	input wire rss_pkg::rss_ready_in_t ready_in,
	input wire logic                  proc_ready,
	input wire logic                  halt_emulation
);
	import rss_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------
	// Shadow of the mapping and of the open cycle
	// ------------------------------------------------------------
	logic        open_reg;
	logic        cfg_comb_reg;
	logic        cyc_comb_reg;
	logic [31:0] mm_reg;
	logic [15:0] im_reg;
	rss_src_t    src_reg;
	wire         wr       = psel & penable & pwrite & pready;
	wire         take     = cyc_start & ~open_reg;
	wire [1:0]   code_now = mm_reg[{cyc_info.addr[19:16], 1'b0} +: 2];
	wire         iob      = im_reg[cyc_info.addr[15:12]];
	rss_src_t    src_now;
	assign src_now = cyc_info.io ? (iob ? RSS_SRC_SB_IO : RSS_SRC_TGT_IO)
		: rss_src_t'({1'b0, code_now});
	wire tgt    = (src_reg == RSS_SRC_TGT_MEM) | (src_reg == RSS_SRC_TGT_IO);
	wire mapped = (src_reg == RSS_SRC_HS_MEM) ? ready_in.high_speed_mem_ready
		: (src_reg == RSS_SRC_OHS_MEM) ? ready_in.optional_high_speed_mem_ready
		: (src_reg == RSS_SRC_SB_MEM) ? ready_in.system_bus_mem_ready
		: ready_in.system_bus_io_ready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_comb_reg <= RSS_COMBINE_RST;
			mm_reg       <= RSS_MEM_MAP_RST;
			im_reg       <= RSS_IO_MAP_RST;
		end else if (wr) begin
			if (paddr == RSS_OFF_CTRL) cfg_comb_reg <= pwdata[0];
			if (paddr == RSS_OFF_MEM_MAP) mm_reg <= pwdata;
			if (paddr == RSS_OFF_IO_MAP) im_reg <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			open_reg     <= 1'b0;
			cyc_comb_reg <= 1'b0;
			src_reg      <= RSS_SRC_TGT_MEM;
		end else begin
			open_reg <= open_reg ? ~proc_ready : cyc_start;
			if (take) cyc_comb_reg <= cfg_comb_reg;
			if (take) src_reg <= src_now;
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	sequence s_cycle_done;
		open_reg && proc_ready;
	endsequence

	a_pready_const: assert property (pready)
		else $error("pready low");
	a_slverr_access: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	a_ready_idle: assert property (!open_reg |-> !proc_ready)
		else $error("ready with no open cycle");
	a_target_only: assert property (open_reg && tgt |-> proc_ready == ready_in.target_ready)
		else $error("target cycle not on target ready");
	a_combine_and: assert property (open_reg && !tgt && cyc_comb_reg
		|-> proc_ready == (ready_in.target_ready & mapped))
		else $error("combined ready wrong");
	a_mapped_only: assert property (open_reg && !tgt && !cyc_comb_reg
		|-> proc_ready == mapped)
		else $error("mapped ready wrong");
	a_ready_pulse: assert property (s_cycle_done |=> !proc_ready)
		else $error("cycle did not close");
	a_halt_cause: assert property ($rose(halt_emulation) |-> $past(take))
		else $error("halt without cycle start");
endmodule

bind rss_ready_select rss_ready_select_asserts rss_ready_select_asserts_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.cyc_start(cyc_start), .cyc_info(cyc_info), .ready_in(ready_in),
	.proc_ready(proc_ready), .halt_emulation(halt_emulation)
);

// [verification/rss_target_model.sv]
// Ready source for one side of a bus cycle: counts wait states, then raises ready.
// Assumes waits is steady at the edge that opens the cycle.
`timescale 1ns/100ps

module rss_target_model (
	// Clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// Processor cycle
	input wire logic       cyc_start,
	input wire logic       proc_ready,
	input wire logic [3:0] waits,
	// Ready out
	output logic           ready
);
	logic       busy_reg;
	logic       tog_reg;
	logic [3:0] cnt_reg;

	// Outside a cycle the level toggles so nothing leans on a stale value
	assign ready = busy_reg ? (cnt_reg == 4'h0) : tog_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'b0;
			tog_reg  <= 1'b0;
			cnt_reg  <= 4'h0;
		end else begin
			tog_reg <= ~tog_reg;
			if (cyc_start && !busy_reg) begin
				busy_reg <= 1'b1;
				cnt_reg  <= waits;
			end else if (busy_reg && proc_ready) busy_reg <= 1'b0;
			else if (busy_reg && cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
		end
	end
endmodule

// [verification/tb_rss_ready_select.sv]
// Testbench for the ready-source selector: registers, bus cycles, recognizers.
// Assumes the checker bind and the ready model compile before this file.
`timescale 1ns/100ps

module tb_rss_ready_select;
	import rss_pkg::*;
	logic          pclk = 1'b0;
	logic          presetn = 1'b0;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic [7:0]    paddr = 8'h00;
	logic [31:0]   pwdata = 32'h0;
	logic          cyc_start = 1'b0;
	rss_cycle_t    cyc_info = '0;
	logic [3:0]    wt = 4'h0;
	logic [3:0]    wm = 4'h0;
	logic [31:0]   prdata, rd, mm, n;
	logic          pready, pslverr, proc_ready, halt_emulation, irq, err;
	logic          tgt_rdy, mem_rdy, comb, io;
	logic [15:0]   im;
	logic [19:0]   a;
	rss_ready_in_t ready_in;
	int            vt, vm;
	integer        seed = 32'ha932;
	int            miscompares = 0;
	int            num_checks = 0;

	assign ready_in = {tgt_rdy, mem_rdy, mem_rdy, mem_rdy, mem_rdy};
	initial forever #4 pclk = ~pclk;

	rss_ready_select rss_ready_select_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cyc_start(cyc_start),
		.cyc_info(cyc_info), .ready_in(ready_in), .proc_ready(proc_ready),
		.halt_emulation(halt_emulation), .irq(irq));
	rss_target_model tgt_model_inst (.pclk(pclk), .presetn(presetn), .cyc_start(cyc_start),
		.proc_ready(proc_ready), .waits(wt), .ready(tgt_rdy));
	rss_target_model mem_model_inst (.pclk(pclk), .presetn(presetn), .cyc_start(cyc_start),
		.proc_ready(proc_ready), .waits(wm), .ready(mem_rdy));

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Full APB transfer; entered right after a rising edge
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		if (k >= 20) begin
			miscompares++;
			final_report();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// One bus cycle; returns the cycles from the opening edge to ready
	task automatic cyc(input logic cio, input logic [19:0] ca);
		cyc_start <= 1'b1;
		cyc_info <= '{io: cio, addr: ca};
		@(posedge pclk);
		cyc_start <= 1'b0;
		n = 1;
		@(negedge pclk);
		while (proc_ready !== 1'b1 && n < 40) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 40) begin
			miscompares++;
			final_report();
		end
		@(posedge pclk);
	endtask

	function automatic logic [31:0] exp_len(input logic c, input logic cio,
		input logic [19:0] ca, input int t, input int m);
		logic tgt;
		tgt = cio ? !im[ca[15:12]] : (mm[{ca[19:16], 1'b0} +: 2] == RSS_MAP_TARGET);
		if (tgt) return 32'(t + 1);
		if (c) return 32'(((t > m) ? t : m) + 1);
		return 32'(m + 1);
	endfunction

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, RSS_OFF_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk(err, 1'b1);
		apb(1'b1, RSS_OFF_CTRL, 32'hffff_fffe);
		apb(1'b0, RSS_OFF_CTRL, 32'h0);
		chk(rd[0], 1'b0);
		$display("test reset done");
		for (int i = 0; i < 48; i++) begin
			if (i % 4 == 0) begin
				comb = 1'($random(seed));
				mm = $random(seed);
				im = 16'($random(seed));
				apb(1'b1, RSS_OFF_CTRL, {31'h0, comb});
				apb(1'b1, RSS_OFF_MEM_MAP, mm);
				apb(1'b1, RSS_OFF_IO_MAP, {16'h0, im});
			end
			a = 20'($random(seed));
			io = 1'($random(seed));
			vm = $unsigned($random(seed)) % 4;
			vt = $unsigned($random(seed)) % (comb ? 4 : vm + 1);
			wm <= 4'(vm);
			wt <= 4'(vt);
			cyc(io, a);
			chk(n, exp_len(comb, io, a, vt, vm));
		end
		$display("test random cycles done");
		mm = 32'h5555_5555;
		im = 16'h0;
		apb(1'b1, RSS_OFF_MEM_MAP, mm);
		apb(1'b1, RSS_OFF_IO_MAP, 32'h0);
		for (int c = 0; c < 2; c++) begin
			apb(1'b1, RSS_OFF_CTRL, 32'(c));
			apb(1'b0, RSS_OFF_CTRL, 32'h0);
			chk(rd, 32'(c));
			// Combine off: a fast target must not end a slow mapped cycle; combine on: a slow target must hold a fast mapped one
			wt <= (c != 0) ? 4'h6 : 4'h0;
			wm <= (c != 0) ? 4'h0 : 4'h6;
			cyc(1'b0, 20'h1_2340);
			chk(n, exp_len(1'(c), 1'b0, 20'h1_2340, (c != 0) ? 6 : 0, (c != 0) ? 0 : 6));
			wt <= 4'h0;
			wm <= 4'h6;
			cyc(1'b1, 20'h0_0040);
			chk(n, 32'h1);
		end
		$display("test corner cycles done");
		apb(1'b1, RSS_OFF_WR_LO, 32'h1_0000);
		apb(1'b1, RSS_OFF_WR_HI, 32'h1_ffff);
		apb(1'b1, RSS_OFF_BRK_REQ, 32'h1);
		cyc(1'b0, 20'h1_2345);
		chk(halt_emulation, 1'b1);
		apb(1'b1, RSS_OFF_CTRL, 32'h2);
		cyc(1'b0, 20'h2_0000);
		chk(halt_emulation, 1'b0);
		apb(1'b1, RSS_OFF_BRK_REQ, 32'h11);
		cyc(1'b0, 20'h2_0000);
		chk(halt_emulation, 1'b1);
		apb(1'b1, RSS_OFF_INT_EN, 32'h1);
		chk(irq, 1'b1);
		apb(1'b1, RSS_OFF_INT_EN, 32'h0);
		chk(irq, 1'b0);
		apb(1'b1, RSS_OFF_INT_CLR, 32'h3);
		apb(1'b0, RSS_OFF_STATUS, 32'h0);
		chk(rd[1:0], 2'h0);
		apb(1'b1, RSS_OFF_BRK_REQ, 32'h4);
		apb(1'b0, RSS_OFF_STATUS, 32'h0);
		chk(rd[1], 1'b0);
		apb(1'b1, RSS_OFF_BRK_REQ, 32'h5);
		apb(1'b0, RSS_OFF_STATUS, 32'h0);
		chk(rd[1], 1'b1);
		apb(1'b1, RSS_OFF_INT_EN, 32'h2);
		chk(irq, 1'b1);
		apb(1'b1, RSS_OFF_INT_CLR, 32'h2);
		chk(irq, 1'b0);
		$display("test recognizers done");
		final_report();
	end
endmodule
